// *** hw/period_match_timer.sv ***
/*
  8-bit period match timer with prescaler, postscaler, axi4-lite slave
  and a sticky, maskable interrupt; assumes one 200 MHz clock, master
  keeps one write and one read outstanding at most.
*/
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "period_timer_params.svh"

module period_match_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  period_timer_pkg::timer_control_t timer_control;
  period_timer_pkg::read_state_t rd_state;
  logic [7:0] count_value;
  logic [7:0] period_match_value;
  logic [1:0] instr_div;
  logic [3:0] prescale_cnt;
  logic [3:0] postscale_cnt;
  logic period_match_flag;
  logic period_match_irq_enable;
  logic have_aw;
  logic have_w;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_count;
  logic wr_period;
  logic wr_irq;
  logic rd_status_clear;
  logic instr_tick;
  logic pre_tick;
  logic [3:0] pre_last;
  logic match;
  logic post_tick;
  // bit 7 is not stored, so only the low seven reset bits land
  localparam logic [7:0] CONTROL_RESET_WORD = `TIMER_CONTROL_RESET;

  // write channel: address and data taken independently, either order
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        s_axi_wready <= 1'b0;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[1:0] == 2'h0) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // readies are flops: low from their accept until the response is taken
  // all four offsets are mapped; a write without lane 0 stores nothing
  assign wr_fire = have_aw && have_w;
  assign wr_ctrl = wr_fire && w_lane0 && aw_addr == `OFF_TIMER_CONTROL;
  assign wr_count = wr_fire && w_lane0 && aw_addr == `OFF_COUNT_VALUE;
  assign wr_period = wr_fire && w_lane0 && aw_addr == `OFF_PERIOD_MATCH_VALUE;
  assign wr_irq = wr_fire && s_axi_wstrb_mask_ok(aw_addr);

  function automatic logic s_axi_wstrb_mask_ok(input logic [3:0] addr);
    s_axi_wstrb_mask_ok = addr == `OFF_IRQ_STATUS;
  endfunction : s_axi_wstrb_mask_ok

  // read channel: one cycle to answer, ready dropped while answer stands
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_state <= period_timer_pkg::RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_RESP_OKAY;
    end
    else
    begin
      case (rd_state)
        period_timer_pkg::RD_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            rd_state <= period_timer_pkg::RD_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rresp <= `AXI_RESP_OKAY;
            case (s_axi_araddr)
              `OFF_TIMER_CONTROL: s_axi_rdata <= {24'h0, 1'b0, timer_control};
              `OFF_COUNT_VALUE: s_axi_rdata <= {24'h0, count_value};
              `OFF_PERIOD_MATCH_VALUE: s_axi_rdata <= {24'h0, period_match_value};
              `OFF_IRQ_STATUS: s_axi_rdata <= {23'h0, period_match_irq_enable,
                                              7'h0, period_match_flag};
              default:
              begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `AXI_RESP_SLVERR;
              end
            endcase
          end
        end
        period_timer_pkg::RD_RESP:
        begin
          if (s_axi_rready)
          begin
            rd_state <= period_timer_pkg::RD_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
        default:
        begin
          rd_state <= period_timer_pkg::RD_IDLE;
          s_axi_rvalid <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      endcase
    end
  end

  assign rd_status_clear = s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_IRQ_STATUS;

  // control register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      timer_control <= CONTROL_RESET_WORD[6:0];
    else if (wr_ctrl)
      timer_control <= w_data[6:0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      period_match_value <= `PERIOD_MATCH_RESET;
    else if (wr_period)
      period_match_value <= w_data[7:0];
  end

  // instruction-rate tick: clk/4, held at zero while stopped
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      instr_div <= 2'h0;
    else if (!timer_control.timer_run_enable || wr_ctrl || wr_count)
      instr_div <= 2'h0;
    else
      instr_div <= instr_div + 2'h1;
  end

  assign instr_tick = timer_control.timer_run_enable && instr_div == `INSTR_CLOCK_DIV;

  always_comb
  begin
    case (timer_control.prescale_select)
      period_timer_pkg::PRESCALE_DIV1: pre_last = 4'h0;
      period_timer_pkg::PRESCALE_DIV4: pre_last = `PRESCALE_DIV4_LAST;
      default: pre_last = `PRESCALE_DIV16_LAST;
    endcase
  end

  // a count or control write in the same cycle wins, so count never steps on it
  assign pre_tick = instr_tick && prescale_cnt >= pre_last && !wr_ctrl && !wr_count;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prescale_cnt <= 4'h0;
    else if (wr_ctrl || wr_count)
      prescale_cnt <= 4'h0;
    else if (pre_tick)
      prescale_cnt <= 4'h0;
    else if (instr_tick)
      prescale_cnt <= prescale_cnt + 4'h1;
  end

  // wrap happens at the match itself: on that tick count loads zero instead of stepping past the period
  assign match = pre_tick && count_value == period_match_value;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_value <= `COUNT_VALUE_RESET;
    else if (wr_count)
      count_value <= w_data[7:0];
    else if (match)
      count_value <= 8'h00;
    else if (pre_tick)
      count_value <= count_value + 8'h01;
  end

  assign post_tick = match && postscale_cnt >= timer_control.postscale_select;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      postscale_cnt <= 4'h0;
    else if (wr_ctrl || wr_count)
      postscale_cnt <= 4'h0;
    else if (post_tick)
      postscale_cnt <= 4'h0;
    else if (match)
      postscale_cnt <= postscale_cnt + 4'h1;
  end

  // set beats the read clear so no event slips between
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      period_match_flag <= 1'b0;
    else if (post_tick)
      period_match_flag <= 1'b1;
    else if (rd_status_clear)
      period_match_flag <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      period_match_irq_enable <= 1'b0;
    else if (wr_irq && w_lane0 == 1'b0)
      period_match_irq_enable <= period_match_irq_enable;
    else if (wr_irq)
      period_match_irq_enable <= w_data[`IRQ_MASK_BIT];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= period_match_flag && period_match_irq_enable;
  end

  sequence s_match_seen;
    match && !wr_count;
  endsequence

  wrap_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    s_match_seen |=> count_value == 8'h00)
    else $error("count did not wrap after match");
  ctrl_bit7_a: assert property (@(posedge clk) disable iff (!reset_n)
    s_axi_rvalid && $past(s_axi_araddr) == `OFF_TIMER_CONTROL && $rose(s_axi_rvalid)
    |-> s_axi_rdata[7] == 1'b0)
    else $error("control bit 7 read as one");
  stop_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !timer_control.timer_run_enable && !wr_count |=> $stable(count_value))
    else $error("count moved while stopped");
  flag_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    post_tick |=> period_match_flag)
    else $error("flag not set by postscaler");
  post_ratio_a: assert property (@(posedge clk) disable iff (!reset_n)
    post_tick |-> postscale_cnt == timer_control.postscale_select)
    else $error("postscale ratio wrong");
  pre_ratio_a: assert property (@(posedge clk) disable iff (!reset_n)
    pre_tick && timer_control.prescale_select == 2'b01 |-> prescale_cnt == 4'h3)
    else $error("prescale by four wrong");
  scaler_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_ctrl |=> prescale_cnt == 4'h0 && postscale_cnt == 4'h0 && $stable(count_value))
    else $error("control write mishandled scalers or count");
  instr_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
    instr_tick |=> !instr_tick [*3])
    else $error("instruction tick faster than clk by four");
  count_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_count |=> count_value == $past(w_data[7:0]))
    else $error("count write lost");
  period_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_period |=> period_match_value == $past(w_data[7:0]))
    else $error("period write lost");

endmodule : period_match_timer

// *** inc/period_timer_params.svh ***
/*
  register offsets, field positions, reset values and timing counts
  of the 8-bit period match timer; assumes a 32-bit axi4-lite map
*/
`ifndef PERIOD_TIMER_PARAMS_SVH
`define PERIOD_TIMER_PARAMS_SVH

`define OFF_TIMER_CONTROL 4'h0
`define OFF_COUNT_VALUE 4'h4
`define OFF_PERIOD_MATCH_VALUE 4'h8
`define OFF_IRQ_STATUS 4'hC

`define TIMER_CONTROL_RESET 8'h00
`define COUNT_VALUE_RESET 8'h00
`define PERIOD_MATCH_RESET 8'hFF
`define TIMER_CONTROL_MASK 8'h7F

`define POSTSCALE_MSB 6
`define POSTSCALE_LSB 3
`define RUN_ENABLE_BIT 2
`define PRESCALE_MSB 1
`define PRESCALE_LSB 0

`define IRQ_STATUS_BIT 0
`define IRQ_MASK_BIT 8

`define INSTR_CLOCK_DIV 2'h3
`define PRESCALE_DIV4_LAST 4'h3
`define PRESCALE_DIV16_LAST 4'hF

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// *** inc/period_timer_pkg.sv ***
/*
  types of the 8-bit period match timer;
  numbers are literals here; none come from period_timer_params.svh
*/
package period_timer_pkg;

  typedef struct packed {
    logic [3:0] postscale_select;
    logic timer_run_enable;
    logic [1:0] prescale_select;
  } timer_control_t;

  typedef enum logic [1:0] {
    PRESCALE_DIV1 = 2'b00,
    PRESCALE_DIV4 = 2'b01,
    PRESCALE_DIV16 = 2'b10
  } prescale_mode_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } read_state_t;

endpackage : period_timer_pkg

// *** tb/period_match_timer_tb_top.sv ***
/*
  self-checking bench of the period match timer over axi4-lite;
  assumes the design's params header and a free-running 200 MHz clock
*/
`timescale 1ns/1ps
`include "period_timer_params.svh"
`define CHECK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module period_match_timer_tb_top;
  logic clk, reset_n, irq;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int bad_count = 0;
  int checked = 0;
  logic [31:0] d;
  logic [1:0] r;

  period_match_timer u_dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic got;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        got = 1'b1;
        resp = s_axi_bresp;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got)
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        got = 1'b1;
        v = s_axi_rdata;
        resp = s_axi_rresp;
      end
    end
  endtask : axi_read

  // reset drops in mid-run too, so handshakes are idled first
  task automatic do_reset;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask : do_reset

  task automatic test_reset_values;
    do_reset();
    axi_read(`OFF_TIMER_CONTROL, d, r);
    `CHECK("control", 32'h0000_0000, d)
    axi_read(`OFF_COUNT_VALUE, d, r);
    `CHECK("count", 32'h0000_0000, d)
    axi_read(`OFF_PERIOD_MATCH_VALUE, d, r);
    `CHECK("period", 32'h0000_00FF, d)
    axi_read(`OFF_IRQ_STATUS, d, r);
    `CHECK("irq reg", 32'h0000_0000, d)
    $display("test reset values done");
  endtask : test_reset_values

  task automatic test_bus_errors;
    axi_write(4'h1, 32'h0000_00FF, r);
    `CHECK("unaligned wr", `AXI_RESP_SLVERR, r)
    axi_read(4'h2, d, r);
    `CHECK("unaligned rd", `AXI_RESP_SLVERR, r)
    `CHECK("unaligned data", 32'h0000_0000, d)
    axi_write(`OFF_TIMER_CONTROL, 32'h0000_00FB, r);
    `CHECK("ctl resp", `AXI_RESP_OKAY, r)
    axi_read(`OFF_TIMER_CONTROL, d, r);
    `CHECK("control bit7", 32'h0000_007B, d)
    $display("test bus errors done");
  endtask : test_bus_errors

  task automatic test_count_rw;
    logic [31:0] c;
    axi_write(`OFF_PERIOD_MATCH_VALUE, 32'h0000_00FF, r);
    axi_write(`OFF_COUNT_VALUE, 32'h0000_0000, r);
    axi_write(`OFF_TIMER_CONTROL, 32'h0000_0004, r);
    repeat (40) @(posedge clk);
    axi_write(`OFF_TIMER_CONTROL, 32'h0000_0000, r);
    axi_read(`OFF_COUNT_VALUE, c, r);
    // one step per 4 clocks at prescale 1, with a few clocks of bus slack
    `CHECK("count climb", 1'b1, (c >= 32'd9 && c <= 32'd13))
    axi_write(`OFF_TIMER_CONTROL, 32'h0000_0001, r);
    axi_read(`OFF_COUNT_VALUE, d, r);
    `CHECK("count kept", c, d)
    repeat (100) @(posedge clk);
    axi_read(`OFF_COUNT_VALUE, d, r);
    `CHECK("count stopped", c, d)
    axi_write(`OFF_COUNT_VALUE, 32'h0000_005A, r);
    axi_read(`OFF_COUNT_VALUE, d, r);
    `CHECK("count rw", 32'h0000_005A, d)
    s_axi_wstrb <= 4'hE;
    axi_write(`OFF_COUNT_VALUE, 32'h0000_0033, r);
    s_axi_wstrb <= 4'hF;
    axi_read(`OFF_COUNT_VALUE, d, r);
    `CHECK("count no lane0", 32'h0000_005A, d)
    axi_write(`OFF_PERIOD_MATCH_VALUE, 32'h0000_003C, r);
    axi_read(`OFF_PERIOD_MATCH_VALUE, d, r);
    `CHECK("period rw", 32'h0000_003C, d)
    $display("test count rw done");
  endtask : test_count_rw

  // every prescale code, postscale at both ends of the field
  task automatic test_scaler_rates;
    int pre[4] = '{0, 1, 2, 3};
    int post[4] = '{0, 3, 15, 1};
    int n, exp_n, dv;
    for (int i = 0; i < 4; i++)
    begin
      dv = (pre[i] == 0) ? 1 : (pre[i] == 1) ? 4 : 16;
      exp_n = 4 * dv * 2 * (post[i] + 1);
      axi_write(`OFF_TIMER_CONTROL, 32'h0000_0000, r);
      axi_write(`OFF_IRQ_STATUS, 32'h0000_0100, r);
      axi_write(`OFF_PERIOD_MATCH_VALUE, 32'h0000_0001, r);
      axi_write(`OFF_COUNT_VALUE, 32'h0000_0000, r);
      axi_read(`OFF_IRQ_STATUS, d, r);
      axi_write(`OFF_TIMER_CONTROL, (post[i] << 3) | 32'h4 | pre[i], r);
      n = 0;
      while (irq !== 1'b1 && n < 5000)
      begin
        @(posedge clk);
        n++;
      end
      `CHECK("match rate", 1'b1, (n >= exp_n - 3 && n <= exp_n + 3))
      axi_write(`OFF_TIMER_CONTROL, 32'h0000_0000, r);
      axi_read(`OFF_IRQ_STATUS, d, r);
      `CHECK("status", 32'h0000_0101, d)
      repeat (2) @(posedge clk);
      `CHECK("irq cleared", 1'b0, irq)
    end
    $display("test scaler rates done");
  endtask : test_scaler_rates

  task automatic test_irq_mask;
    axi_write(`OFF_IRQ_STATUS, 32'h0000_0000, r);
    axi_write(`OFF_COUNT_VALUE, 32'h0000_0000, r);
    axi_write(`OFF_TIMER_CONTROL, 32'h0000_0004, r);
    repeat (40) @(posedge clk);
    `CHECK("irq masked", 1'b0, irq)
    axi_write(`OFF_TIMER_CONTROL, 32'h0000_0000, r);
    axi_read(`OFF_IRQ_STATUS, d, r);
    `CHECK("flag masked", 32'h0000_0001, d)
    axi_read(`OFF_IRQ_STATUS, d, r);
    `CHECK("flag read clear", 32'h0000_0000, d)
    $display("test irq mask done");
  endtask : test_irq_mask

  task automatic test_done;
    $display("counts: checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  initial
  begin
    reset_n = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0000_0000;
    // all byte lanes set unless a test narrows them
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    test_reset_values();
    test_bus_errors();
    test_count_rw();
    test_scaler_rates();
    test_irq_mask();
    // second reset lands mid-count, with control and mask set
    axi_write(`OFF_IRQ_STATUS, 32'h0000_0100, r);
    axi_write(`OFF_TIMER_CONTROL, 32'h0000_007F, r);
    test_reset_values();
    test_done();
  end

  // tests take well under 10000 cycles
  initial
  begin
    #250000;
    bad_count++;
    test_done();
  end
endmodule : period_match_timer_tb_top
